// ### shared/dpie_pkg.sv
// Function
// - Indirect load reads the bus at the pointer; sizes up to 16 bits.
// - Indirect load data, or the pointer itself, is sent after guard time.
// - Indirect store writes received data at the pointer; sizes up to 16 bits.
// - Each instruction follows a sync; every successful indirect store returns an acknowledge.
// - Pointer-select 0x2 takes address-size bytes as new pointer, then acknowledges.
// - Select 0x0 keeps the pointer; 0x1 advances it by data bytes after writing.
// - Repeated store data may follow each acknowledge without sync or instruction.
// - Control space load: address in opcode, 16 bytes, always one byte.
// - Control space load byte is sent after the guard time.
// - Control space store writes one received byte, no response.
// - Repeat loads a one-byte count, at most 255; wider sizes unsupported.
// - The instruction after repeat runs count plus one times.
// - Only the first repeated instruction has sync and instruction frames.
// - Any instruction may repeat except repeat itself.
// - A repeat runs until exhausted; only a break aborts it.
// - Unlock accepts only 64-bit signatures, frame counted by size, no response.
// - Info-block flag makes unlock send the block after guard time, up to 128 bits.
// - Unlock size field sets frames received or transmitted.
// - A guard of configurable idle bits precedes transmit after receive.
// - Size fields are two bits: 00 one byte, 01 two bytes, rest reserved.
package dpie_pkg;
	localparam logic [2:0] INS_LDS = 3'h0;
	localparam logic [2:0] INS_LD = 3'h1;
	localparam logic [2:0] INS_STS = 3'h2;
	localparam logic [2:0] INS_ST = 3'h3;
	localparam logic [2:0] INS_CSR_SPACE_READ_INSTR = 3'h4;
	localparam logic [2:0] INS_RPT = 3'h5;
	localparam logic [2:0] INS_CSR_SPACE_WRITE_INSTR = 3'h6;
	localparam logic [2:0] INS_KEY = 3'h7;
	localparam logic [1:0] PSEL_KEEP = 2'h0;
	localparam logic [1:0] PSEL_INC = 2'h1;
	localparam logic [1:0] PSEL_ADDR = 2'h2;
	localparam logic [1:0] PSEL_RSVD = 2'h3;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] KSZ_64 = 2'h0;
	localparam logic [1:0] KSZ_128 = 2'h1;
	localparam logic [4:0] KEY_FRAMES = 5'h08;
	localparam logic [4:0] INFO_FRAMES = 5'h10;
	localparam logic [7:0] ACK_BYTE = 8'h40;
	localparam logic [2:0] GVAL_RST = 3'h1;
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_STATUS = 3'h1;
	localparam logic [2:0] IDX_POINTER = 3'h2;
	localparam logic [2:0] IDX_KEY_LO = 3'h3;
	localparam logic [2:0] IDX_KEY_HI = 3'h4;
	localparam int CTRL_KEYCLR_BIT = 8;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_OPC = 4'h1,
		ST_DISP = 4'h2,
		ST_RXB = 4'h3,
		ST_BUS = 4'h4,
		ST_GUARD = 4'h5,
		ST_TX = 4'h6
	} dpie_state_t;

	typedef struct packed {
		dpie_state_t st;
		logic [7:0] op;
		logic [15:0] ptr;
		logic [7:0] rpt;
		logic rpt_pend;
		logic rpt_act;
		logic [4:0] cnt;
		logic [4:0] idx;
		logic [15:0] dbuf;
		logic txinfo;
		logic [63:0] key;
		logic key_ok;
		logic [15:0][7:0] csr;
		logic [2:0] gcnt;
		logic [2:0] gval;
		logic txv;
		logic [7:0] txd;
		logic breq;
		logic bwe;
		logic [15:0] baddr;
		logic [7:0] bwd;
		logic avwait;
		logic [31:0] avrd;
	} dpie_regs_t;

	localparam dpie_regs_t REGS_RST = '{st: ST_IDLE, gval: GVAL_RST, avwait: 1'b1, default: '0};
endpackage

// ### hw/dpie_core.sv
`timescale 1ns/10ps
module dpie_core #(
	parameter logic [127:0] INFO_BLOCK = 128'h0123_4567_89AB_CDEF_0123_4567_89AB_CDEF // Arbitrary
) (
	input logic i_clk_sys, // System clock, 10 MHz
	input logic i_rst_n, // Async reset, active low
	input logic [2:0] i_avs_address, // Avalon word index
	input logic i_avs_read, // Avalon read
	input logic i_avs_write, // Avalon write
	input logic [31:0] i_avs_writedata, // Avalon write data
	input logic [3:0] i_avs_byteenable, // Avalon byte enables
	output logic [31:0] o_avs_readdata, // Avalon read data
	output logic o_avs_waitrequest, // Avalon wait
	input logic i_rx_valid, // Received byte strobe
	input logic [7:0] i_rx_data, // Received byte
	input logic i_rx_sync, // Sync character seen
	input logic i_rx_break, // Break character seen
	input logic i_bit_tick, // One pulse per bit time
	output logic o_tx_valid, // Byte to send
	output logic [7:0] o_tx_data, // Send byte
	input logic i_tx_ready, // Transmitter took byte
	output logic o_bus_req, // System bus request
	output logic o_bus_we, // System bus write
	output logic [15:0] o_bus_addr, // System bus address
	output logic [7:0] o_bus_wdata, // System bus write data
	input logic i_bus_ack, // System bus done
	input logic [7:0] i_bus_rdata // System bus read data
);
	dpie_pkg::dpie_regs_t s_reg;
	dpie_pkg::dpie_regs_t s_next;
	logic [2:0] ins;
	logic [1:0] psel;
	logic [1:0] sz;
	logic [4:0] dsz;
	logic [4:0] kfr;
	logic [4:0] n_idx;
	logic last;
	logic fin;

	function automatic logic [4:0] sz_bytes(input logic [1:0] c);
		// Reserved codes give zero and the instruction is dropped
		return (c == dpie_pkg::SIZE_BYTE) ? 5'h01 : (c == dpie_pkg::SIZE_WORD) ? 5'h02 : 5'h00;
	endfunction

	function automatic logic [7:0] byte_sel(input logic info, input logic [15:0] d,
		input logic [4:0] k);
		return info ? INFO_BLOCK[{k[3:0], 3'h0} +: 8] : d[{k[0], 3'h0} +: 8];
	endfunction

	assign ins = s_reg.op[7:5];
	assign psel = s_reg.op[3:2];
	assign sz = s_reg.op[1:0];
	assign dsz = sz_bytes(sz);
	assign kfr = (sz == dpie_pkg::KSZ_64) ? dpie_pkg::KEY_FRAMES :
		(sz == dpie_pkg::KSZ_128) ? dpie_pkg::INFO_FRAMES : 5'h00;
	assign n_idx = s_reg.idx + 5'h01;
	assign last = (n_idx == s_reg.cnt);

	always_comb begin
		s_next = s_reg;
		fin = 1'b0;
		if (s_reg.st != dpie_pkg::ST_GUARD) begin
			s_next.gcnt = 3'h0;
		end
		// One wait cycle per access keeps the read mux off the bus path
		if (s_reg.avwait) begin
			if (i_avs_read || i_avs_write) begin
				s_next.avwait = 1'b0;
				unique case (i_avs_address)
					dpie_pkg::IDX_CTRL: s_next.avrd = {29'h0000_0000, s_reg.gval};
					dpie_pkg::IDX_STATUS: s_next.avrd = {14'h0000, s_reg.key_ok, s_reg.rpt_act,
						s_reg.rpt, 4'h0, s_reg.st};
					dpie_pkg::IDX_POINTER: s_next.avrd = {16'h0000, s_reg.ptr};
					dpie_pkg::IDX_KEY_LO: s_next.avrd = s_reg.key[31:0];
					dpie_pkg::IDX_KEY_HI: s_next.avrd = s_reg.key[63:32];
					default: s_next.avrd = 32'h0000_0000;
				endcase
			end
		end else begin
			s_next.avwait = 1'b1;
			if (i_avs_write && i_avs_address == dpie_pkg::IDX_CTRL) begin
				if (i_avs_byteenable[0]) begin
					s_next.gval = i_avs_writedata[2:0];
				end
				if (i_avs_byteenable[1] && i_avs_writedata[dpie_pkg::CTRL_KEYCLR_BIT]) begin
					s_next.key_ok = 1'b0;
				end
			end
		end
		unique case (s_reg.st)
			dpie_pkg::ST_IDLE: begin
				if (i_rx_sync) begin
					s_next.st = dpie_pkg::ST_OPC;
				end
			end
			dpie_pkg::ST_OPC: begin
				if (i_rx_valid) begin
					s_next.op = i_rx_data;
					s_next.st = dpie_pkg::ST_DISP;
				end
			end
			dpie_pkg::ST_DISP: begin
				s_next.idx = 5'h00;
				s_next.txinfo = 1'b0;
				s_next.dbuf = 16'h0000;
				if (ins != dpie_pkg::INS_RPT && s_reg.rpt_pend) begin
					s_next.rpt_act = 1'b1;
					s_next.rpt_pend = 1'b0;
				end
				unique case (ins)
					dpie_pkg::INS_LD: begin
						s_next.cnt = dsz;
						if (dsz == 5'h00 || psel == dpie_pkg::PSEL_RSVD) begin
							fin = 1'b1;
						end else if (psel == dpie_pkg::PSEL_ADDR) begin
							s_next.dbuf = s_reg.ptr;
							s_next.st = dpie_pkg::ST_GUARD;
						end else begin
							s_next.st = dpie_pkg::ST_BUS;
						end
					end
					dpie_pkg::INS_ST: begin
						s_next.cnt = dsz;
						if (dsz == 5'h00 || psel == dpie_pkg::PSEL_RSVD) begin
							fin = 1'b1;
						end else begin
							s_next.st = dpie_pkg::ST_RXB;
						end
					end
					dpie_pkg::INS_CSR_SPACE_READ_INSTR: begin
						s_next.dbuf = {8'h00, s_reg.csr[s_reg.op[3:0]]};
						s_next.cnt = 5'h01;
						s_next.st = dpie_pkg::ST_GUARD;
					end
					dpie_pkg::INS_CSR_SPACE_WRITE_INSTR: begin
						s_next.cnt = 5'h01;
						s_next.st = dpie_pkg::ST_RXB;
					end
					dpie_pkg::INS_RPT: begin
						s_next.rpt_act = 1'b0;
						if (sz == dpie_pkg::SIZE_BYTE) begin
							s_next.cnt = 5'h01;
							s_next.st = dpie_pkg::ST_RXB;
						end else begin
							fin = 1'b1;
						end
					end
					dpie_pkg::INS_KEY: begin
						s_next.cnt = kfr;
						if (kfr == 5'h00) begin
							fin = 1'b1;
						end else if (s_reg.op[2]) begin
							s_next.txinfo = 1'b1;
							s_next.st = dpie_pkg::ST_GUARD;
						end else if (kfr == dpie_pkg::KEY_FRAMES) begin
							s_next.st = dpie_pkg::ST_RXB;
						end else begin
							fin = 1'b1;
						end
					end
					default: fin = 1'b1;
				endcase
			end
			dpie_pkg::ST_RXB: begin
				// In a repeat the data frames arrive with no new sync
				if (i_rx_valid) begin
					if (ins == dpie_pkg::INS_KEY) begin
						s_next.key = {i_rx_data, s_reg.key[63:8]};
					end
					s_next.dbuf[{s_reg.idx[0], 3'h0} +: 8] = i_rx_data;
					s_next.idx = n_idx;
					if (last) begin
						s_next.idx = 5'h00;
						unique case (ins)
							dpie_pkg::INS_ST: begin
								if (psel == dpie_pkg::PSEL_ADDR) begin
									s_next.ptr = s_next.dbuf;
									s_next.dbuf = {8'h00, dpie_pkg::ACK_BYTE};
									s_next.cnt = 5'h01;
									s_next.st = dpie_pkg::ST_GUARD;
								end else begin
									s_next.st = dpie_pkg::ST_BUS;
								end
							end
							dpie_pkg::INS_CSR_SPACE_WRITE_INSTR: begin
								s_next.csr[s_reg.op[3:0]] = i_rx_data;
								fin = 1'b1;
							end
							dpie_pkg::INS_RPT: begin
								s_next.rpt = i_rx_data;
								s_next.rpt_pend = 1'b1;
								fin = 1'b1;
							end
							default: begin
								s_next.key_ok = 1'b1;
								fin = 1'b1;
							end
						endcase
					end
				end
			end
			dpie_pkg::ST_BUS: begin
				if (!s_reg.breq) begin
					s_next.breq = 1'b1;
					s_next.bwe = (ins == dpie_pkg::INS_ST);
					s_next.baddr = s_reg.ptr + {11'h000, s_reg.idx};
					s_next.bwd = s_reg.dbuf[{s_reg.idx[0], 3'h0} +: 8];
				end else if (i_bus_ack) begin
					s_next.breq = 1'b0;
					if (!s_reg.bwe) begin
						s_next.dbuf[{s_reg.idx[0], 3'h0} +: 8] = i_bus_rdata;
					end
					s_next.idx = n_idx;
					if (last) begin
						s_next.idx = 5'h00;
						if (psel == dpie_pkg::PSEL_INC) begin
							s_next.ptr = s_reg.ptr + {11'h000, s_reg.cnt};
						end
						if (s_reg.bwe) begin
							s_next.dbuf = {8'h00, dpie_pkg::ACK_BYTE};
							s_next.cnt = 5'h01;
						end
						s_next.st = dpie_pkg::ST_GUARD;
					end
				end
			end
			dpie_pkg::ST_GUARD: begin
				// Idle bits counted in bit ticks; setting 0 still gives one
				if (i_bit_tick) begin
					if (s_reg.gcnt == s_reg.gval) begin
						s_next.st = dpie_pkg::ST_TX;
						s_next.txv = 1'b1;
						s_next.txd = byte_sel(s_reg.txinfo, s_reg.dbuf, s_reg.idx);
					end else begin
						s_next.gcnt = s_reg.gcnt + 3'h1;
					end
				end
			end
			dpie_pkg::ST_TX: begin
				if (i_tx_ready) begin
					if (last) begin
						s_next.txv = 1'b0;
						fin = 1'b1;
					end else begin
						s_next.idx = n_idx;
						s_next.txd = byte_sel(s_reg.txinfo, s_reg.dbuf, n_idx);
					end
				end
			end
			default: s_next.st = dpie_pkg::ST_IDLE;
		endcase
		if (fin) begin
			if (s_next.rpt_act && s_reg.rpt != 8'h00) begin
				s_next.rpt = s_reg.rpt - 8'h01;
				s_next.st = dpie_pkg::ST_DISP;
			end else begin
				s_next.rpt_act = 1'b0;
				s_next.st = dpie_pkg::ST_IDLE;
			end
		end
		// Break is the only way out of a running repeat
		if (i_rx_break) begin
			s_next.st = dpie_pkg::ST_IDLE;
			s_next.rpt_act = 1'b0;
			s_next.rpt_pend = 1'b0;
			s_next.breq = 1'b0;
			s_next.txv = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= dpie_pkg::REGS_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_avs_readdata = s_reg.avrd;
	assign o_avs_waitrequest = s_reg.avwait;
	assign o_tx_valid = s_reg.txv;
	assign o_tx_data = s_reg.txd;
	assign o_bus_req = s_reg.breq;
	assign o_bus_we = s_reg.bwe;
	assign o_bus_addr = s_reg.baddr;
	assign o_bus_wdata = s_reg.bwd;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	sequence seq_guard_end;
		s_reg.st == dpie_pkg::ST_GUARD && i_bit_tick && s_reg.gcnt == s_reg.gval && !i_rx_break;
	endsequence
	sequence seq_store_done;
		s_reg.st == dpie_pkg::ST_BUS && o_bus_req && o_bus_we && i_bus_ack && last && !i_rx_break;
	endsequence
	sequence seq_ptr_last;
		s_reg.st == dpie_pkg::ST_RXB && ins == dpie_pkg::INS_ST &&
		psel == dpie_pkg::PSEL_ADDR && i_rx_valid && last && !i_rx_break;
	endsequence

	chk_bus_addr: assert property (
		$rose(o_bus_req) |-> o_bus_addr == s_reg.ptr + {11'h000, s_reg.idx})
		else $error("bus address not taken from pointer");
	chk_bus_hold: assert property (
		o_bus_req && !i_bus_ack && !i_rx_break |=> o_bus_req && $stable(o_bus_addr) &&
		$stable(o_bus_we) && $stable(o_bus_wdata))
		else $error("bus request changed before acknowledge");
	chk_guard_first: assert property (
		seq_guard_end |=> o_tx_valid ##0 s_reg.st == dpie_pkg::ST_TX)
		else $error("transmit did not start after guard");
	chk_tx_guarded: assert property (
		$rose(o_tx_valid) |-> $past(s_reg.st) == dpie_pkg::ST_GUARD && $past(i_bit_tick))
		else $error("transmit started without guard time");
	chk_tx_hold: assert property (
		o_tx_valid && !i_tx_ready && !i_rx_break |=> o_tx_valid && $stable(o_tx_data))
		else $error("transmit byte dropped before taken");
	chk_store_ack: assert property (
		seq_store_done |=> s_reg.st == dpie_pkg::ST_GUARD ##0
		s_reg.dbuf[7:0] == dpie_pkg::ACK_BYTE)
		else $error("no acknowledge after store");
	chk_ptr_write: assert property (
		seq_ptr_last ##0 s_reg.cnt == 5'h01 |=>
		s_reg.ptr == {8'h00, $past(i_rx_data)} ##0 s_reg.st == dpie_pkg::ST_GUARD)
		else $error("pointer store wrong");
	chk_ptr_word: assert property (
		seq_ptr_last ##0 s_reg.cnt == 5'h02 |=>
		s_reg.ptr == {$past(i_rx_data), $past(s_reg.dbuf[7:0])})
		else $error("two-byte pointer store wrong");
	chk_post_inc: assert property (
		seq_store_done ##0 psel == dpie_pkg::PSEL_INC |=>
		s_reg.ptr == $past(s_reg.ptr) + {11'h000, $past(s_reg.cnt)})
		else $error("pointer not advanced by data size");
	chk_ptr_keep: assert property (
		seq_store_done ##0 psel == dpie_pkg::PSEL_KEEP |=> s_reg.ptr == $past(s_reg.ptr))
		else $error("pointer moved without post-increment");
	chk_size_drop: assert property (
		s_reg.st == dpie_pkg::ST_DISP && (ins == dpie_pkg::INS_LD || ins == dpie_pkg::INS_ST)
		&& sz[1] && !i_rx_break |=>
		s_reg.st == dpie_pkg::ST_IDLE || s_reg.st == dpie_pkg::ST_DISP)
		else $error("reserved size was executed");
	chk_csr_space_read_instr_byte: assert property (
		s_reg.st == dpie_pkg::ST_DISP && ins == dpie_pkg::INS_CSR_SPACE_READ_INSTR && !i_rx_break |=>
		s_reg.cnt == 5'h01 ##0
		s_reg.dbuf[7:0] == $past(s_reg.csr[s_reg.op[3:0]]))
		else $error("control space load wrong");
	chk_csr_write: assert property (
		s_reg.st == dpie_pkg::ST_RXB && ins == dpie_pkg::INS_CSR_SPACE_WRITE_INSTR && i_rx_valid |=>
		s_reg.csr[$past(s_reg.op[3:0])] == $past(i_rx_data) ##0
		s_reg.st != dpie_pkg::ST_GUARD)
		else $error("control space store wrong");
	chk_rpt_load: assert property (
		s_reg.st == dpie_pkg::ST_RXB && ins == dpie_pkg::INS_RPT && i_rx_valid &&
		!i_rx_break |=> s_reg.rpt == $past(i_rx_data) ##0
		s_reg.rpt_pend && !s_reg.rpt_act)
		else $error("repeat count not loaded");
	chk_rpt_size: assert property (
		s_reg.st == dpie_pkg::ST_DISP && ins == dpie_pkg::INS_RPT &&
		sz != dpie_pkg::SIZE_BYTE && !i_rx_break |=>
		s_reg.st == dpie_pkg::ST_IDLE)
		else $error("wide repeat size accepted");
	chk_rpt_arm: assert property (
		s_reg.st == dpie_pkg::ST_DISP && ins != dpie_pkg::INS_RPT && s_reg.rpt_pend &&
		s_reg.rpt != 8'h00 && !i_rx_break |=>
		s_reg.rpt_act && !s_reg.rpt_pend)
		else $error("repeat not started by next instruction");
	chk_rpt_count: assert property (
		fin && s_next.rpt_act && s_reg.rpt != 8'h00 && !i_rx_break |=>
		s_reg.st == dpie_pkg::ST_DISP ##0
		s_reg.rpt == $past(s_reg.rpt) - 8'h01)
		else $error("repeat count not consumed");
	chk_rpt_last: assert property (
		fin && s_reg.rpt_act && s_reg.rpt == 8'h00 && !i_rx_break |=>
		s_reg.st == dpie_pkg::ST_IDLE ##0
		!s_reg.rpt_act)
		else $error("repeat ran past its count");
	chk_rpt_self: assert property (
		s_reg.st == dpie_pkg::ST_DISP && ins == dpie_pkg::INS_RPT |=> !s_reg.rpt_act)
		else $error("repeat instruction was repeated");
	chk_key_done: assert property (
		s_reg.st == dpie_pkg::ST_RXB && ins == dpie_pkg::INS_KEY && i_rx_valid && last &&
		!i_rx_break |=> s_reg.key_ok ##0
		!o_tx_valid && s_reg.key[63:56] == $past(i_rx_data))
		else $error("signature not taken silently");
	chk_key_size: assert property (
		s_reg.st == dpie_pkg::ST_DISP && ins == dpie_pkg::INS_KEY && !s_reg.op[2] &&
		kfr != dpie_pkg::KEY_FRAMES && !i_rx_break |=>
		s_reg.st != dpie_pkg::ST_RXB)
		else $error("unsupported signature size accepted");
	chk_info_start: assert property (
		s_reg.st == dpie_pkg::ST_DISP && ins == dpie_pkg::INS_KEY && s_reg.op[2] &&
		kfr != 5'h00 && !i_rx_break |=> s_reg.st == dpie_pkg::ST_GUARD ##0
		s_reg.txinfo && s_reg.cnt == $past(kfr))
		else $error("info block not started");
	chk_break_abort: assert property (
		i_rx_break |=> s_reg.st == dpie_pkg::ST_IDLE && !s_reg.rpt_act && !o_tx_valid)
		else $error("break did not abort");
endmodule

// ### bench/dpie_link_model.sv
`timescale 1ns/10ps
module dpie_link_model (
	input wire logic i_clk_sys, // System clock
	input wire logic i_tx_valid, // Byte offered by device
	input wire logic [7:0] i_tx_data, // Byte from device
	output logic o_rx_valid, // Byte strobe to device
	output logic [7:0] o_rx_data, // Byte to device
	output logic o_rx_sync, // Sync character
	output logic o_rx_break, // Break character
	output logic o_bit_tick, // Bit time pulse
	output logic o_tx_ready // Byte taken
);
	int slow = 0;
	logic [1:0] tdiv = 2'h0;
	initial begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
		o_rx_sync = 1'b0;
		o_rx_break = 1'b0;
		o_bit_tick = 1'b0;
		o_tx_ready = 1'b0;
	end
	// Four system clocks per bit keeps guard waits short
	always @(posedge i_clk_sys) begin
		tdiv <= tdiv + 2'h1;
		o_bit_tick <= (tdiv == 2'h3);
	end
	task automatic send_sync();
		@(posedge i_clk_sys);
		o_rx_sync <= 1'b1;
		@(posedge i_clk_sys);
		o_rx_sync <= 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] d);
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b1;
		o_rx_data <= d;
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b0;
		// Released line shows the inverse so a stale sample is caught
		o_rx_data <= ~d;
	endtask
	task automatic send_break();
		@(posedge i_clk_sys);
		o_rx_break <= 1'b1;
		@(posedge i_clk_sys);
		o_rx_break <= 1'b0;
	endtask
	// Waits for the answer before sending on
	task automatic get_byte(output logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		while (i_tx_valid !== 1'b1 && n < 2000) begin
			@(posedge i_clk_sys);
			n++;
		end
		repeat (slow) @(posedge i_clk_sys);
		o_tx_ready <= 1'b1;
		@(posedge i_clk_sys);
		d = (i_tx_valid === 1'b1) ? i_tx_data : 8'hxx;
		o_tx_ready <= 1'b0;
	endtask
endmodule

// ### bench/debug_port_instruction_engine_tb_top.sv
`timescale 1ns/10ps
module debug_port_instruction_engine_tb_top;
	localparam logic [127:0] INFO = 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F; // Arbitrary
	typedef struct packed {
		logic [3:0] a;
		logic [7:0] d;
	} dpie_row_t;
	dpie_row_t rows [4] = '{'{4'h0, 8'h00}, '{4'h3, 8'hA5}, '{4'h9, 8'h3C}, '{4'hF, 8'hFF}};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] av_addr;
	logic av_rd;
	logic av_wr;
	logic [31:0] av_wd;
	logic [3:0] av_be;
	logic [31:0] av_rdata;
	logic av_wait;
	logic rx_valid, rx_sync, rx_break, bit_tick, tx_ready, tx_valid;
	logic [7:0] rx_data, tx_data, b;
	logic bus_req, bus_we;
	logic bus_ack = 1'b0;
	logic [15:0] bus_addr;
	logic [7:0] bus_wdata;
	logic [7:0] bus_rdata = 8'h00;
	logic [7:0] mem [256];
	logic [31:0] q;
	int bcnt = 0;
	int n_fail = 0;
	int total_checks = 0;

	always #50 clk_sys = ~clk_sys;

	dpie_core #(.INFO_BLOCK(INFO)) i_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
		.i_avs_writedata(av_wd), .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata),
		.o_avs_waitrequest(av_wait), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
		.i_rx_sync(rx_sync), .i_rx_break(rx_break), .i_bit_tick(bit_tick),
		.o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
		.o_bus_req(bus_req), .o_bus_we(bus_we), .o_bus_addr(bus_addr),
		.o_bus_wdata(bus_wdata), .i_bus_ack(bus_ack), .i_bus_rdata(bus_rdata));

	dpie_link_model i_link (.i_clk_sys(clk_sys), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_sync(rx_sync),
		.o_rx_break(rx_break), .o_bit_tick(bit_tick), .o_tx_ready(tx_ready));

	// System bus slave, answers on the third requested cycle
	always @(posedge clk_sys) begin
		bus_ack <= 1'b0;
		bus_rdata <= ~bus_rdata;
		if (bus_req === 1'b1 && !bus_ack) begin
			if (bcnt == 2) begin
				bus_ack <= 1'b1;
				bcnt <= 0;
				if (bus_we)
					mem[bus_addr[7:0]] <= bus_wdata;
				else
					bus_rdata <= mem[bus_addr[7:0]];
			end else begin
				bcnt <= bcnt + 1;
			end
		end
	end

	task automatic conclude();
		$display("Counts: %0d checks, %0d mismatches", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic av(input logic we, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] r);
		av_rd <= !we;
		av_wr <= we;
		av_addr <= a;
		av_wd <= d;
		// Only the watchdog ends a wait that never answers
		do begin
			@(posedge clk_sys);
		end while (av_wait !== 1'b0);
		r = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic ins(input logic [7:0] op);
		i_link.send_sync();
		i_link.send_byte(op);
	endtask
	// A silent device shows no byte for a long span
	task automatic quiet();
		logic seen;
		seen = 1'b0;
		repeat (60) begin
			@(posedge clk_sys);
			seen = seen | (tx_valid !== 1'b0);
		end
		chk({31'h0, seen}, 32'h0);
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end

	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		av_addr <= 3'h0;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
		av_wd <= 32'h0000_0000;
		av_be <= 4'hF;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		av(1'b0, 3'h0, 32'h0, q);
		chk(q, 32'h0000_0001);
		av(1'b0, 3'h7, 32'h0, q);
		chk(q, 32'h0000_0000);
		av(1'b1, 3'h0, 32'h0000_0002, q);
		av(1'b0, 3'h0, 32'h0, q);
		chk(q, 32'h0000_0002);
		av_be <= 4'hE;
		av(1'b1, 3'h0, 32'h0000_0105, q);
		av_be <= 4'hF;
		av(1'b0, 3'h0, 32'h0, q);
		chk(q, 32'h0000_0002);
		$display("Test registers done");
		foreach (rows[i]) begin
			ins({4'hC, rows[i].a});
			i_link.send_byte(rows[i].d);
			quiet();
			ins({4'h8, rows[i].a});
			i_link.get_byte(b);
			chk(b, rows[i].d);
		end
		$display("Test control space done");
		i_link.send_byte(8'h80);
		quiet();
		i_link.slow = 3;
		ins(8'h69);
		i_link.send_byte(8'h10);
		i_link.send_byte(8'h00);
		i_link.get_byte(b);
		chk(b, 8'h40);
		av(1'b0, 3'h2, 32'h0, q);
		chk(q, 32'h0000_0010);
		ins(8'h29);
		i_link.get_byte(b);
		chk(b, 8'h10);
		i_link.get_byte(b);
		chk(b, 8'h00);
		$display("Test pointer done");
		ins(8'hA0);
		i_link.send_byte(8'h02);
		ins(8'h65);
		for (int i = 0; i < 3; i++) begin
			i_link.send_byte(8'hB0 + 8'(2 * i));
			i_link.send_byte(8'hB1 + 8'(2 * i));
			i_link.get_byte(b);
			chk(b, 8'h40);
		end
		for (int k = 0; k < 6; k++)
			chk(mem[8'h10 + 8'(k)], 8'hB0 + 8'(k));
		av(1'b0, 3'h2, 32'h0, q);
		chk(q, 32'h0000_0016);
		av(1'b0, 3'h1, 32'h0, q);
		chk(q[16], 1'b0);
		ins(8'h60);
		i_link.send_byte(8'h77);
		i_link.get_byte(b);
		chk(b, 8'h40);
		av(1'b0, 3'h2, 32'h0, q);
		chk(q, 32'h0000_0016);
		chk(mem[8'h16], 8'h77);
		$display("Test indirect store done");
		i_link.slow = 0;
		ins(8'hA0);
		i_link.send_byte(8'h01);
		ins(8'h24);
		i_link.get_byte(b);
		chk(b, 8'h77);
		i_link.get_byte(b);
		chk(b, 8'h17 ^ 8'h5A);
		av(1'b0, 3'h2, 32'h0, q);
		chk(q, 32'h0000_0018);
		$display("Test indirect load done");
		ins(8'hE0);
		for (int k = 1; k <= 8; k++)
			i_link.send_byte(8'(k));
		quiet();
		av(1'b0, 3'h3, 32'h0, q);
		chk(q, 32'h0403_0201);
		av(1'b0, 3'h4, 32'h0, q);
		chk(q, 32'h0807_0605);
		av(1'b0, 3'h1, 32'h0, q);
		chk(q[17], 1'b1);
		av_be <= 4'h1;
		av(1'b1, 3'h0, 32'h0000_0102, q);
		av(1'b0, 3'h1, 32'h0, q);
		chk(q[17], 1'b1);
		av_be <= 4'h2;
		av(1'b1, 3'h0, 32'h0000_0105, q);
		av_be <= 4'hF;
		av(1'b0, 3'h1, 32'h0, q);
		chk(q[17], 1'b0);
		av(1'b0, 3'h0, 32'h0, q);
		chk(q, 32'h0000_0002);
		ins(8'hE5);
		for (int k = 0; k < 16; k++) begin
			i_link.get_byte(b);
			chk(b, INFO[8 * k +: 8]);
		end
		$display("Test unlock done");
		ins(8'h68);
		i_link.send_byte(8'h30);
		i_link.get_byte(b);
		chk(b, 8'h40);
		av(1'b0, 3'h2, 32'h0, q);
		chk(q, 32'h0000_0030);
		ins(8'h6B);
		i_link.send_byte(8'h55);
		ins(8'hA1);
		i_link.send_byte(8'h03);
		ins(8'hE1);
		i_link.send_byte(8'h11);
		quiet();
		av(1'b0, 3'h2, 32'h0, q);
		chk(q, 32'h0000_0030);
		av(1'b0, 3'h1, 32'h0, q);
		chk(q[16:8], 9'h000);
		av(1'b0, 3'h3, 32'h0, q);
		chk(q, 32'h0403_0201);
		$display("Test reserved codes done");
		ins(8'hA0);
		i_link.send_byte(8'h05);
		ins(8'h60);
		i_link.send_byte(8'h99);
		i_link.get_byte(b);
		chk(b, 8'h40);
		av(1'b0, 3'h1, 32'h0, q);
		chk(q[16], 1'b1);
		i_link.send_break();
		av(1'b0, 3'h1, 32'h0, q);
		chk(q[16], 1'b0);
		ins(8'h83);
		i_link.get_byte(b);
		chk(b, 8'hA5);
		$display("Test break done");
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({av_wait, tx_valid, bus_req}, 32'h0000_0004);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		av(1'b0, 3'h0, 32'h0, q);
		chk(q, dpie_pkg::GVAL_RST);
		av(1'b0, 3'h2, 32'h0, q);
		chk(q, 32'h0000_0000);
		$display("Test reset done");
		conclude();
	end
endmodule
